// File: pkg/ilio_pkg.sv
// Shared constants, codes and carriers of the ISA lane I/O port block.
package ilio_pkg;

  // Base port addresses picked by the two base address shunts {1-2, 3-4}.
  localparam logic [1:0] ILIO_BASE_SEL_100 = 2'h0;
  localparam logic [1:0] ILIO_BASE_SEL_120 = 2'h1;
  localparam logic [1:0] ILIO_BASE_SEL_180 = 2'h2;
  localparam logic [1:0] ILIO_BASE_SEL_210 = 2'h3;
  localparam logic [9:0] ILIO_BASE_100 = 10'h100;
  localparam logic [9:0] ILIO_BASE_120 = 10'h120;
  localparam logic [9:0] ILIO_BASE_180 = 10'h180;
  localparam logic [9:0] ILIO_BASE_210 = 10'h210;

  // Port offsets from the base address.
  localparam logic [9:0] ILIO_OFS_STATUS = 10'h000;
  localparam logic [9:0] ILIO_OFS_CLEAR = 10'h001;
  localparam logic [9:0] ILIO_OFS_HEADER = 10'h002;
  localparam int ILIO_OFS_W = 2;

  // Field layout and reset values.
  localparam int ILIO_RELAY_BITS = 4;
  localparam logic [3:0] ILIO_RELAY_RST = 4'h0;
  localparam logic [7:0] ILIO_LATCH_RST = 8'h00;
  localparam logic [7:0] ILIO_BUF_RST = 8'h00;
  localparam logic [7:0] ILIO_HEADER_RST = 8'hFF;
  localparam logic [7:0] ILIO_LED_RST = 8'h00;
  // Lane A inputs sit at bit 0 of each nibble and have no polarity shunt.
  localparam int ILIO_LANE_W = 4;

  // Interrupt line shunts in the order 3, 4, 5, 7, 9.
  localparam int ILIO_IRQ_N = 5;

  // Relay source shunt codes {2-3, 1-2}.
  typedef enum logic [1:0] {
    ILIO_SRC_OFF = 2'b00,
    ILIO_SRC_ON = 2'b01,
    ILIO_SRC_SW = 2'b10
  } ilio_src_t;

  // Bus access states, one-hot.
  typedef enum logic [2:0] {
    ILIO_ST_IDLE = 3'b001,
    ILIO_ST_READ = 3'b010,
    ILIO_ST_WRITE = 3'b100
  } ilio_state_t;

  // ISA bus pins as sampled.
  typedef struct packed {
    logic [9:0] addr;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [7:0] wdata;
  } ilio_bus_t;

  // Field inputs and jumper shunts as sampled.
  typedef struct packed {
    logic [7:0] lane_in;
    logic [1:0] base_sel;
    logic [4:0] irq_sel;
    logic led_off;
    logic [2:0] polarity;
    logic [7:0] relay_src;
  } ilio_cfg_t;

endpackage : ilio_pkg

// File: hw/ilio_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module ilio_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin side and synchronised side
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stage1_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_q <= pin_in;
      sync_out <= stage1_q;
    end
  end

endmodule : ilio_sync
`default_nettype wire

// File: hw/ilio_in_capture.sv
// Input polarity correction and sticky input buffers for both lanes.
`timescale 1ns/100ps
`default_nettype none
module ilio_in_capture
  import ilio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Synchronised inputs and polarity shunts
  input wire logic [7:0] lane_in,
  input wire logic [2:0] polarity,
  input wire logic clear,
  // Captured state
  output logic [7:0] asserted_q,
  output logic [7:0] buffer_q,
  output logic new_set
);

  logic [7:0] invert_w;
  logic [7:0] asserted_d;
  logic [7:0] buffer_d;

  // Letter A has no shunt; B, C, D share one shunt per letter across lanes.
  assign invert_w = {polarity, 1'b0, polarity, 1'b0};
  assign asserted_d = lane_in ^ invert_w;
  // A set arriving with the clear survives it.
  assign buffer_d = (buffer_q & ~{8{clear}}) | asserted_q;
  // A bit that survives the clear because its input is still asserted counts as a fresh set.
  assign new_set = |(asserted_q & (~buffer_q | {8{clear}}));

  // The registered level is the detector stage for the A inputs.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      asserted_q <= ILIO_BUF_RST;
      buffer_q <= ILIO_BUF_RST;
    end
    else
    begin
      asserted_q <= asserted_d;
      buffer_q <= buffer_d;
    end
  end

endmodule : ilio_in_capture
`default_nettype wire

// File: hw/ilio_ports.sv
// ISA lane I/O port block: port decode, latches, input status and interrupt.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Ports decode at base 100h, 120h, 180h or 210h chosen by two shunts.
// - Interrupt drives exactly one shunt-chosen line 3, 4, 5, 7, 9, or none.
// - Read offset 0 returns lane one inputs in bits 0-3, lane two in 4-7.
// - Write offset 0 loads relay latch bits 0-3; bits 4-7 ignored.
// - Write offset 2 loads the eight-bit header latch.
// - Read offset 1 clears the latched input buffers, except bits whose input is still asserted.
// - Interrupt stays latched until the clearing read; host must perform it.
// - Each lane A input passes a flip-flop stage to become a level.
// - B, C, D polarity set per letter; shunt means active low.
// - Each relay output is forced off, forced on, or follows its latch bit.
// - The four relay source choices act independently.
// - Header lines show the inverse of the header latch bits.
// - Output lights follow latch bits; input lights follow input states.
// - One shunt blanks all indicator lights without touching the logic.
module ilio_ports
  import ilio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // ISA bus
  input wire logic [9:0] isa_addr,
  input wire logic isa_aen,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic [7:0] isa_data_in,
  output logic [7:0] isa_data_out,
  output logic isa_data_oe,
  output logic [4:0] isa_irq_out,
  // Field inputs, lane one in bits 0-3 and lane two in bits 4-7
  input wire logic [7:0] lane_inputs,
  // Jumper shunts
  input wire logic [1:0] base_address_jumper,
  input wire logic [4:0] irq_select_jumper,
  input wire logic indicator_disable_jumper,
  input wire logic [2:0] input_polarity_jumper,
  input wire logic [7:0] relay_source_jumper,
  // Relay outputs
  output logic lane_one_relay_out_first,
  output logic lane_one_relay_out_second,
  output logic lane_two_relay_out_first,
  output logic lane_two_relay_out_second,
  // Header and indicator outputs
  output logic [7:0] inverted_ttl_header,
  output logic [7:0] input_led,
  output logic [3:0] output_led
);

  // The default base is the fallback, so its shunt code needs no branch of its own.
  function automatic logic [9:0] base_of(input logic [1:0] sel);
    logic [9:0] base;
    base = ILIO_BASE_180;
    if (sel == ILIO_BASE_SEL_100)
      base = ILIO_BASE_100;
    else if (sel == ILIO_BASE_SEL_120)
      base = ILIO_BASE_120;
    else if (sel == ILIO_BASE_SEL_210)
      base = ILIO_BASE_210;
    return base;
  endfunction : base_of

  // Code 11 is not a shunt setting on the card, so it leaves the relay off.
  function automatic logic relay_drive(input logic [1:0] src, input logic latch_bit);
    logic drive;
    drive = 1'b0;
    if (src == ILIO_SRC_ON)
      drive = 1'b1;
    else if (src == ILIO_SRC_SW)
      drive = latch_bit;
    return drive;
  endfunction : relay_drive

  ilio_bus_t bus_raw;
  ilio_bus_t bus_s;
  ilio_cfg_t cfg_raw;
  ilio_cfg_t cfg_s;

  assign bus_raw = '{addr: isa_addr, aen: isa_aen, ior_n: isa_ior_n, iow_n: isa_iow_n,
                     wdata: isa_data_in};
  assign cfg_raw = '{lane_in: lane_inputs, base_sel: base_address_jumper, irq_sel: irq_select_jumper,
                     led_off: indicator_disable_jumper, polarity: input_polarity_jumper,
                     relay_src: relay_source_jumper};

  ilio_sync #(.WIDTH($bits(ilio_bus_t))) u_bus_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(bus_raw),
    .sync_out(bus_s)
  );

  ilio_sync #(.WIDTH($bits(ilio_cfg_t))) u_cfg_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(cfg_raw),
    .sync_out(cfg_s)
  );

  // Port decode.
  logic [9:0] base_w;
  logic [9:0] offset_w;
  logic in_window_w;
  logic hit_status_w;
  logic hit_clear_w;
  logic hit_header_w;
  logic read_hit_w;
  logic write_hit_w;

  assign base_w = base_of(cfg_s.base_sel);
  assign offset_w = bus_s.addr - base_w;
  // DMA cycles carry AEN high and must never match a port.
  assign in_window_w = !bus_s.aen && (bus_s.addr >= base_w);
  assign hit_status_w = in_window_w && (offset_w == ILIO_OFS_STATUS);
  assign hit_clear_w = in_window_w && (offset_w == ILIO_OFS_CLEAR);
  assign hit_header_w = in_window_w && (offset_w == ILIO_OFS_HEADER);
  assign read_hit_w = hit_status_w || hit_clear_w;
  assign write_hit_w = hit_status_w || hit_header_w;

  // Bus access sequencing on the strobe edges.
  ilio_state_t state_q;
  ilio_state_t state_d;
  logic [ILIO_OFS_W-1:0] ofs_q;
  logic [ILIO_OFS_W-1:0] ofs_d;
  logic read_start_w;
  logic write_start_w;
  logic clear_pulse_w;
  logic write_commit_w;

  always_comb
  begin
    state_d = state_q;
    read_start_w = 1'b0;
    write_start_w = 1'b0;
    clear_pulse_w = 1'b0;
    write_commit_w = 1'b0;
    case (state_q)
      ILIO_ST_IDLE:
      begin
        if (!bus_s.ior_n && read_hit_w)
        begin
          state_d = ILIO_ST_READ;
          read_start_w = 1'b1;
        end
        else if (!bus_s.iow_n && write_hit_w)
        begin
          state_d = ILIO_ST_WRITE;
          write_start_w = 1'b1;
        end
      end
      ILIO_ST_READ:
      begin
        if (bus_s.ior_n)
        begin
          state_d = ILIO_ST_IDLE;
          // Clearing at the end of the read lets the host see the bits first.
          clear_pulse_w = (ofs_q == ILIO_OFS_CLEAR[ILIO_OFS_W-1:0]);
        end
      end
      ILIO_ST_WRITE:
      begin
        // Write data is taken at the trailing strobe edge, when ISA holds it stable.
        if (bus_s.iow_n)
        begin
          state_d = ILIO_ST_IDLE;
          write_commit_w = 1'b1;
        end
      end
      default:
      begin
        state_d = ILIO_ST_IDLE;
      end
    endcase
  end

  assign ofs_d = (read_start_w || write_start_w) ? offset_w[ILIO_OFS_W-1:0] : ofs_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= ILIO_ST_IDLE;
      ofs_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ofs_q <= ofs_d;
    end
  end

  // Input capture and interrupt latch.
  logic [7:0] asserted_w;
  logic [7:0] buffer_w;
  logic new_set_w;
  logic irq_req_q;
  logic irq_req_d;

  ilio_in_capture u_capture (
    .core_clk(core_clk),
    .reset(reset),
    .lane_in(cfg_s.lane_in),
    .polarity(cfg_s.polarity),
    .clear(clear_pulse_w),
    .asserted_q(asserted_w),
    .buffer_q(buffer_w),
    .new_set(new_set_w)
  );

  // A request already pending is not re-issued; only the clearing read frees it.
  // An input still asserted through the clear comes back as a new set and a new request.
  assign irq_req_d = new_set_w || (irq_req_q && !clear_pulse_w);

  // Two shunts at once is a fault; no line is driven then.
  logic [4:0] irq_route_w;
  assign irq_route_w = $onehot(cfg_s.irq_sel) ? cfg_s.irq_sel : 5'h00;

  // Output latches.
  logic [3:0] relay_latch_q;
  logic [7:0] header_latch_q;
  logic load_relay_w;
  logic load_header_w;

  assign load_relay_w = write_commit_w && (ofs_q == ILIO_OFS_STATUS[ILIO_OFS_W-1:0]);
  assign load_header_w = write_commit_w && (ofs_q == ILIO_OFS_HEADER[ILIO_OFS_W-1:0]);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_req_q <= 1'b0;
      relay_latch_q <= ILIO_RELAY_RST;
      header_latch_q <= ILIO_LATCH_RST;
    end
    else
    begin
      irq_req_q <= irq_req_d;
      if (load_relay_w)
        relay_latch_q <= bus_s.wdata[ILIO_RELAY_BITS-1:0];
      if (load_header_w)
        header_latch_q <= bus_s.wdata;
    end
  end

  // Each relay takes its own source shunt pair.
  logic [3:0] relay_drive_w;
  genvar gi;
  generate
    for (gi = 0; gi < ILIO_RELAY_BITS; gi++)
    begin : g_relay
      assign relay_drive_w[gi] = relay_drive(cfg_s.relay_src[2*gi +: 2], relay_latch_q[gi]);
    end
  endgenerate

  // Read data and registered outputs.
  logic reading_w;
  assign reading_w = (state_d == ILIO_ST_READ);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      isa_data_out <= ILIO_LATCH_RST;
      isa_data_oe <= 1'b0;
      isa_irq_out <= 5'h00;
      {lane_two_relay_out_second, lane_two_relay_out_first,
       lane_one_relay_out_second, lane_one_relay_out_first} <= ILIO_RELAY_RST;
      inverted_ttl_header <= ILIO_HEADER_RST;
      input_led <= ILIO_LED_RST;
      output_led <= ILIO_RELAY_RST;
    end
    else
    begin
      if (read_start_w)
        isa_data_out <= buffer_w;
      isa_data_oe <= reading_w;
      isa_irq_out <= irq_route_w & {ILIO_IRQ_N{irq_req_q}};
      {lane_two_relay_out_second, lane_two_relay_out_first,
       lane_one_relay_out_second, lane_one_relay_out_first} <= relay_drive_w;
      inverted_ttl_header <= ~header_latch_q;
      input_led <= cfg_s.led_off ? ILIO_LED_RST : asserted_w;
      output_led <= cfg_s.led_off ? ILIO_RELAY_RST : relay_latch_q;
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_irq_held: assert property (irq_req_q && !clear_pulse_w |=> irq_req_q)
    else $error("interrupt request dropped without a clearing read");
  chk_irq_single: assert property ($onehot0(isa_irq_out))
    else $error("more than one interrupt line driven");
  chk_irq_route: assert property (irq_req_q ##1 irq_req_q |-> isa_irq_out == $past(irq_route_w))
    else $error("interrupt not on the selected line");
  chk_irq_release: assert property (clear_pulse_w && !new_set_w |=> !irq_req_q ##1 isa_irq_out == 5'h00)
    else $error("interrupt not released by clearing read");
  chk_clear_buffers: assert property (clear_pulse_w && asserted_w == 8'h00 |=> buffer_w == 8'h00)
    else $error("input buffers not cleared by offset 1 read");
  chk_status_data: assert property (read_start_w |=> isa_data_out == $past(buffer_w) && isa_data_oe)
    else $error("status read returned wrong byte");
  chk_relay_latch: assert property (load_relay_w |=> relay_latch_q == $past(bus_s.wdata[3:0]))
    else $error("relay latch not loaded");
  chk_header_inv: assert property (load_header_w |=> ##1 inverted_ttl_header == ~$past(bus_s.wdata, 2))
    else $error("header lines not inverse of written byte");
  chk_relay_forced: assert property (cfg_s.relay_src[1:0] == ILIO_SRC_ON |=> lane_one_relay_out_first)
    else $error("forced-on relay not driven");
  chk_led_blank: assert property (cfg_s.led_off |=> input_led == 8'h00 && output_led == 4'h0)
    else $error("indicator lights not blanked");
  chk_dma_ignored: assert property (bus_s.aen && state_q == ILIO_ST_IDLE |=> state_q == ILIO_ST_IDLE)
    else $error("port access taken during a DMA cycle");

  // An input that stays asserted through the clear must re-arm its bit and the request.
  chk_irq_reraise: assert property (clear_pulse_w && asserted_w != 8'h00 |=>
    irq_req_q && buffer_w == $past(asserted_w))
    else $error("asserted input did not re-arm its buffer bit and the request");

  // Latches move only on a committed write to their own offset.
  chk_latch_hold: assert property (!write_commit_w |=>
    $stable(relay_latch_q) && $stable(header_latch_q))
    else $error("output latch changed without a write");
  chk_dma_no_start: assert property (bus_s.aen |-> !read_start_w && !write_start_w)
    else $error("access started while AEN high");
  chk_oe_drop: assert property (state_q == ILIO_ST_READ && bus_s.ior_n |=> !isa_data_oe)
    else $error("data bus still driven after the read strobe ended");
  chk_relay_off: assert property (cfg_s.relay_src[1:0] == ILIO_SRC_OFF |=> !lane_one_relay_out_first)
    else $error("forced-off relay driven");
  chk_led_follow: assert property (!cfg_s.led_off |=>
    input_led == $past(asserted_w) && output_led == $past(relay_latch_q))
    else $error("indicator lights do not follow inputs and latch");

  cov_clear_read: cover property (clear_pulse_w && irq_req_q);
  cov_header_write: cover property (load_header_w);
  cov_irq_line: cover property (isa_irq_out != 5'h00);
  cov_irq_reraise: cover property (clear_pulse_w && asserted_w != 8'h00);
  cov_relay_forced: cover property (cfg_s.relay_src[3:2] == ILIO_SRC_ON && !relay_latch_q[1]);

endmodule : ilio_ports
`default_nettype wire

// File: test/ilio_host_model.sv
// Behavioural ISA host that issues port reads and writes to the card.
`timescale 1ns/100ps
`default_nettype none
module ilio_host_model (
  // Clock
  input wire logic core_clk,
  // Bus lines driven by the host
  output logic [9:0] isa_addr,
  output logic isa_aen,
  output logic isa_ior_n,
  output logic isa_iow_n,
  output logic [7:0] isa_data_in,
  // Bus lines driven by the card
  input wire logic [7:0] isa_data_out,
  input wire logic isa_data_oe
);
  logic [9:0] base = 10'h180;
  logic dma = 1'b0;

  initial
  begin
    isa_addr = 10'h3FF;
    isa_aen = 1'b0;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    isa_data_in = 8'hFF;
  end

  // Address and data float once released, so they show the inverse of the last value.
  task automatic release_bus();
    repeat (4) @(negedge core_clk);
    isa_addr = ~isa_addr;
    isa_data_in = ~isa_data_in;
    isa_aen = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : release_bus

  task automatic start(input logic [9:0] ofs);
    @(negedge core_clk);
    isa_aen = dma;
    isa_addr = base + ofs;
  endtask : start

  // The strobe stays low long enough to pass the card's input synchronisers.
  task automatic bus_write(input logic [9:0] ofs, input logic [7:0] val);
    start(ofs);
    isa_data_in = val;
    isa_iow_n = 1'b0;
    repeat (4) @(negedge core_clk);
    isa_iow_n = 1'b1;
    release_bus();
  endtask : bus_write

  task automatic bus_read(input logic [9:0] ofs, output logic [7:0] val, output logic seen);
    int n;
    start(ofs);
    isa_ior_n = 1'b0;
    seen = 1'b0;
    val = 8'h00;
    n = 0;
    while (!seen && n < 8)
    begin
      @(negedge core_clk);
      n++;
      if (isa_data_oe === 1'b1)
      begin
        seen = 1'b1;
        val = isa_data_out;
      end
    end
    isa_ior_n = 1'b1;
    release_bus();
  endtask : bus_read
endmodule : ilio_host_model
`default_nettype wire

// File: test/ilio_ports_tb_top.sv
// Self-checking testbench of the ISA lane I/O port block.
`timescale 1ns/100ps
`default_nettype none
module ilio_ports_tb_top;
  import ilio_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] isa_addr;
  logic isa_aen, isa_ior_n, isa_iow_n, isa_data_oe;
  logic [7:0] isa_data_in, isa_data_out, inverted_ttl_header, input_led;
  logic [4:0] isa_irq_out;
  logic [3:0] output_led;
  logic lane_one_relay_out_first, lane_one_relay_out_second;
  logic lane_two_relay_out_first, lane_two_relay_out_second;
  logic [7:0] lane_inputs = 8'h00;
  logic [1:0] base_address_jumper = ILIO_BASE_SEL_180;
  logic [4:0] irq_select_jumper = 5'h00;
  logic indicator_disable_jumper = 1'b0;
  logic [2:0] input_polarity_jumper = 3'h0;
  logic [7:0] relay_source_jumper = 8'hAA;
  logic [7:0] relays;
  logic [7:0] rdv;
  logic seen;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [9:0] bases [4] = '{ILIO_BASE_100, ILIO_BASE_120, ILIO_BASE_180, ILIO_BASE_210};
  logic [7:0] hdr [4] = '{8'h5A, 8'hA5, 8'h01, 8'h80};

  assign relays = {4'h0, lane_two_relay_out_second, lane_two_relay_out_first,
                   lane_one_relay_out_second, lane_one_relay_out_first};

  ilio_ports ilio_ports_inst (
    .core_clk, .reset, .isa_addr, .isa_aen, .isa_ior_n, .isa_iow_n, .isa_data_in,
    .isa_data_out, .isa_data_oe, .isa_irq_out, .lane_inputs, .base_address_jumper,
    .irq_select_jumper, .indicator_disable_jumper, .input_polarity_jumper,
    .relay_source_jumper, .lane_one_relay_out_first, .lane_one_relay_out_second,
    .lane_two_relay_out_first, .lane_two_relay_out_second, .inverted_ttl_header,
    .input_led, .output_led
  );

  ilio_host_model ilio_host_model_inst (
    .core_clk, .isa_addr, .isa_aen, .isa_ior_n, .isa_iow_n, .isa_data_in,
    .isa_data_out, .isa_data_oe
  );

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [9:0] ofs, input logic [7:0] val);
    ilio_host_model_inst.bus_write(ofs, val);
  endtask : wr

  task automatic rd(input logic [9:0] ofs);
    ilio_host_model_inst.bus_read(ofs, rdv, seen);
  endtask : rd

  // A hang costs a mismatch and still reaches the closing report.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    chk(inverted_ttl_header, 8'hFF);
    chk(relays | {4'h0, output_led}, 8'h00);
    chk({3'h0, isa_irq_out}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      base_address_jumper = i[1:0];
      repeat (4) @(negedge core_clk);
      ilio_host_model_inst.base = bases[i];
      wr(ILIO_OFS_HEADER, hdr[i]);
      chk(inverted_ttl_header, ~hdr[i]);
      ilio_host_model_inst.base = bases[(i + 1) % 4];
      wr(ILIO_OFS_HEADER, 8'h00);
      chk(inverted_ttl_header, ~hdr[i]);
    end
    ilio_host_model_inst.base = ILIO_BASE_210;
    wr(ILIO_OFS_HEADER, 8'h00);
    chk(inverted_ttl_header, 8'hFF);
    base_address_jumper = ILIO_BASE_SEL_180;
    ilio_host_model_inst.base = ILIO_BASE_180;
    repeat (4) @(negedge core_clk);
    wr(ILIO_OFS_STATUS, 8'hF5);
    chk(relays, 8'h05);
    chk({4'h0, output_led}, 8'h05);
    // Lane one E off, lane one F forced on, lane two E software, lane two F code 11.
    relay_source_jumper = 8'hE4;
    repeat (4) @(negedge core_clk);
    chk(relays, 8'h06);
    chk({4'h0, output_led}, 8'h05);
    wr(ILIO_OFS_STATUS, 8'h00);
    chk(relays, 8'h02);
    relay_source_jumper = 8'hAA;
    ilio_host_model_inst.dma = 1'b1;
    wr(ILIO_OFS_HEADER, 8'h3C);
    chk(inverted_ttl_header, 8'hFF);
    rd(ILIO_OFS_STATUS);
    chk({7'h0, seen}, 8'h00);
    ilio_host_model_inst.dma = 1'b0;
    rd(ILIO_OFS_HEADER);
    chk({7'h0, seen}, 8'h00);
    irq_select_jumper = 5'h04;
    lane_inputs = 8'h22;
    repeat (6) @(negedge core_clk);
    chk({3'h0, isa_irq_out}, 8'h04);
    chk(input_led, 8'h22);
    lane_inputs = 8'h00;
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h22);
    chk({7'h0, seen}, 8'h01);
    // A two-cycle pulse on a lane A input must still be caught.
    lane_inputs = 8'h01;
    repeat (2) @(negedge core_clk);
    lane_inputs = 8'h00;
    repeat (6) @(negedge core_clk);
    chk({3'h0, isa_irq_out}, 8'h04);
    rd(ILIO_OFS_CLEAR);
    chk(rdv, 8'h23);
    chk({3'h0, isa_irq_out}, 8'h00);
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h00);
    input_polarity_jumper = 3'h7;
    lane_inputs = 8'hEE;
    repeat (6) @(negedge core_clk);
    rd(ILIO_OFS_CLEAR);
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h00);
    lane_inputs = 8'hEA;
    repeat (6) @(negedge core_clk);
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h04);
    // An input still asserted through the clearing read re-arms its bit and the request.
    rd(ILIO_OFS_CLEAR);
    chk(rdv, 8'h04);
    chk({3'h0, isa_irq_out}, 8'h04);
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h04);
    wr(ILIO_OFS_STATUS, 8'h01);
    indicator_disable_jumper = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(input_led | {4'h0, output_led}, 8'h00);
    chk(relays, 8'h01);
    chk({3'h0, isa_irq_out}, 8'h04);
    irq_select_jumper = 5'h05;
    repeat (4) @(negedge core_clk);
    chk({3'h0, isa_irq_out}, 8'h00);
    irq_select_jumper = 5'h10;
    repeat (4) @(negedge core_clk);
    chk({3'h0, isa_irq_out}, 8'h10);
    lane_inputs = 8'hEE;
    repeat (6) @(negedge core_clk);
    rd(ILIO_OFS_CLEAR);
    chk({3'h0, isa_irq_out}, 8'h00);
    // A mid-run reset must drop latches written earlier, not only the power-up values.
    wr(ILIO_OFS_HEADER, 8'hC3);
    chk(inverted_ttl_header, 8'h3C);
    reset = 1'b1;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(inverted_ttl_header, 8'hFF);
    chk(relays, 8'h00);
    rd(ILIO_OFS_STATUS);
    chk(rdv, 8'h00);
    print_verdict();
  end
endmodule : ilio_ports_tb_top
`default_nettype wire
